// ---- pkg/bacr_regs.vh ----
// register offsets, field positions, memory slots, reset values and trim constants of the
// address and current-trim register bank; definitions only
`ifndef BACR_REGS_VH
`define BACR_REGS_VH

// ----------------------------------------------------------------------
// command and register offsets
// ----------------------------------------------------------------------
`define BACR_OFS_STORE_ALL 8'h15
`define BACR_OFS_SYS_CFG 8'hA0
`define BACR_OFS_OWN_ADDR 8'hA2
`define BACR_OFS_VID_ADDR 8'hA3
`define BACR_OFS_CUR_TRIM 8'hA4

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BACR_SYS_OVERRIDE_BIT 0
`define BACR_OWN_ADDR_MSB 6
`define BACR_OWN_ADDR_LSB 0
`define BACR_OWN_RSVD_BIT 7
`define BACR_VID_ADDR_MSB 3
`define BACR_VID_ADDR_LSB 0
`define BACR_GAIN_MSB 7
`define BACR_GAIN_LSB 4
`define BACR_OFS_MSB 3
`define BACR_OFS_LSB 0

// ----------------------------------------------------------------------
// non-volatile slots and factory contents (arbitrary values; the trim default gives unity gain and a -0.25 A offset)
// ----------------------------------------------------------------------
`define BACR_NVM_DEPTH 4
`define BACR_SLOT_SYS_CFG 2'h0
`define BACR_SLOT_OWN_ADDR 2'h1
`define BACR_SLOT_VID_ADDR 2'h2
`define BACR_SLOT_CUR_TRIM 2'h3
`define BACR_SLOT_LAST 2'h3
`define BACR_DEF_SYS_CFG 8'h00
`define BACR_DEF_OWN_ADDR 8'h10
`define BACR_DEF_VID_ADDR 8'h00
`define BACR_DEF_CUR_TRIM 8'h77

// ----------------------------------------------------------------------
// current trim arithmetic: gain (193 + code) / 200, offset in lsb of 0.25 A
// ----------------------------------------------------------------------
`define BACR_GAIN_BASE 9'h0C1
`define BACR_GAIN_DIV 32'h000000C8
`define BACR_OFS_POS_BIAS 5'h07
`define BACR_OFS_NEG_BIAS 5'h08

`endif

// ---- rtl/bacr_nvm.v ----
// non-volatile backup of the register bank, one byte per slot
// assumes a synchronous single-port use: one read or one write per cycle;
// contents survive reset_n, which stands for the supply reset
`timescale 1ns/1ps
`include "bacr_regs.vh"

module bacr_nvm (
  input wire clk,           // clock
  input wire ce,            // clock enable
  input wire wrEn,          // write strobe
  input wire [1:0] addr,    // slot index
  input wire [7:0] wrData,  // write data
  output reg [7:0] rdData   // registered read data
);

  reg [7:0] mem [0:`BACR_NVM_DEPTH-1];

  // ----------------------------------------------------------------------
  // factory contents; storage itself takes no reset so it outlives it
  // ----------------------------------------------------------------------
  initial begin
    mem[0] = `BACR_DEF_SYS_CFG;
    mem[1] = `BACR_DEF_OWN_ADDR;
    mem[2] = `BACR_DEF_VID_ADDR;
    mem[3] = `BACR_DEF_CUR_TRIM;
  end

  always @(posedge clk) begin
    if (ce) begin
      if (wrEn) begin
        mem[addr] <= wrData;
      end
      rdData <= mem[addr];
    end
  end

endmodule

// ---- rtl/bacr_top.v ----
// address and output-current trim register bank of the management port
// assumes the serial framing is decoded outside: one byte transaction
// per cmdValid pulse; reset_n is the supply reset
`timescale 1ns/1ps
`include "bacr_regs.vh"

module bacr_top (
  input wire clk,               // 250 MHz clock
  input wire reset_n,           // async supply reset, active low
  input wire ce,                // clock enable, freezes all state
  input wire [6:0] strapAddr,   // address decoded from the strap resistor
  input wire cmdValid,          // one byte transaction request
  input wire cmdWrite,          // 1 write, 0 read
  input wire [7:0] cmdAddr,     // command or register offset
  input wire [7:0] cmdData,     // write byte
  input wire rawValid,          // raw current sample strobe
  input wire [15:0] rawCurrent, // raw current, lsb 0.25 A
  output reg rspValid,          // answer strobe
  output reg rspNack,           // request refused
  output reg [7:0] rspData,     // read byte
  output reg ready,             // power-up load finished
  output reg busy,              // load or store in progress
  output reg [6:0] ownAddress,  // bus address in use
  output reg addressOverride,   // override adopted at power-up
  output reg [3:0] vidAddress,  // vid bus address in use
  output wire reportValid,      // trimmed report strobe
  output wire [15:0] outputCurrentReport // trimmed current report
);

  // ----------------------------------------------------------------------
  // state and working registers
  // ----------------------------------------------------------------------
  localparam [1:0] ST_LOAD = 2'b00;
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_STORE = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] slot_q;
  reg [1:0] slot_d;
  reg loadPend_q;
  reg [1:0] loadSlot_q;
  reg [7:0] sysCfg_q;
  reg [6:0] ownAddrReg_q;
  reg [3:0] vidAddrReg_q;
  reg [7:0] curTrim_q;
  reg [6:0] strapHeld_q;
  reg nvmWrEn;
  reg [7:0] nvmWrData;
  wire [7:0] nvmRdData;
  wire isWrite;
  wire isRead;
  wire addrSysCfg;
  wire addrOwn;
  wire addrVid;
  wire addrTrim;
  wire addrStore;
  wire mapped;
  reg [7:0] readByte;

  // ----------------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------------
  // store-all is a command, not a register: write only, nothing to read back
  assign isWrite = cmdValid & cmdWrite;
  assign isRead = cmdValid & ~cmdWrite;
  assign addrSysCfg = (cmdAddr == `BACR_OFS_SYS_CFG);
  assign addrOwn = (cmdAddr == `BACR_OFS_OWN_ADDR);
  assign addrVid = (cmdAddr == `BACR_OFS_VID_ADDR);
  assign addrTrim = (cmdAddr == `BACR_OFS_CUR_TRIM);
  assign addrStore = (cmdAddr == `BACR_OFS_STORE_ALL);
  assign mapped = addrSysCfg | addrOwn | addrVid | addrTrim;

  // read mux; the own-address readback follows the adopted source
  always @* begin
    readByte = 8'h00;
    if (addrSysCfg) begin
      readByte = sysCfg_q;
    end else if (addrOwn) begin
      if (addressOverride) begin
        readByte = {1'b0, ownAddrReg_q}; // stored value, bit 7 zero
      end else begin
        readByte = {1'b0, strapHeld_q}; // strapped address read back
      end
    end else if (addrVid) begin
      readByte = {4'h0, vidAddrReg_q}; // upper nibble reads zero
    end else if (addrTrim) begin
      readByte = curTrim_q;
    end else begin
      readByte = 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // load and store sequencer
  // ----------------------------------------------------------------------
  always @* begin
    state_d = state_q;
    slot_d = slot_q;
    case (state_q)
      ST_LOAD: begin
        if (slot_q == `BACR_SLOT_LAST) begin
          state_d = ST_IDLE;
          slot_d = 2'h0;
        end else begin
          slot_d = slot_q + 2'h1;
        end
      end
      ST_IDLE: begin
        // store-all only accepted between transactions
        if (isWrite && addrStore) begin
          state_d = ST_STORE;
          slot_d = 2'h0;
        end
      end
      ST_STORE: begin
        if (slot_q == `BACR_SLOT_LAST) begin
          state_d = ST_IDLE;
          slot_d = 2'h0;
        end else begin
          slot_d = slot_q + 2'h1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        slot_d = 2'h0;
      end
    endcase
  end

  // store writes the working bytes slot by slot
  always @* begin
    nvmWrEn = 1'b0;
    nvmWrData = 8'h00;
    if (state_q == ST_STORE) begin
      nvmWrEn = 1'b1;
      if (slot_q == `BACR_SLOT_SYS_CFG) begin
        nvmWrData = sysCfg_q;
      end else if (slot_q == `BACR_SLOT_OWN_ADDR) begin
        nvmWrData = {1'b0, ownAddrReg_q};
      end else if (slot_q == `BACR_SLOT_VID_ADDR) begin
        nvmWrData = {4'h0, vidAddrReg_q};
      end else begin
        nvmWrData = curTrim_q;
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_LOAD;
      slot_q <= 2'h0;
      loadPend_q <= 1'b0;
      loadSlot_q <= 2'h0;
    end else if (ce) begin
      state_q <= state_d;
      slot_q <= slot_d;
      loadPend_q <= (state_q == ST_LOAD);
      loadSlot_q <= slot_q;
    end
  end

  // ----------------------------------------------------------------------
  // working registers: restored from backup, then written by the host
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sysCfg_q <= `BACR_DEF_SYS_CFG;
      ownAddrReg_q <= 7'h00;
      vidAddrReg_q <= 4'h0;
      curTrim_q <= `BACR_DEF_CUR_TRIM;
    end else if (ce) begin
      // restore wins over host writes; those are refused at the answer anyway
      if (loadPend_q) begin
        if (loadSlot_q == `BACR_SLOT_SYS_CFG) begin
          sysCfg_q <= nvmRdData;
        end else if (loadSlot_q == `BACR_SLOT_OWN_ADDR) begin
          ownAddrReg_q <= nvmRdData[`BACR_OWN_ADDR_MSB:`BACR_OWN_ADDR_LSB];
        end else if (loadSlot_q == `BACR_SLOT_VID_ADDR) begin
          vidAddrReg_q <= nvmRdData[`BACR_VID_ADDR_MSB:`BACR_VID_ADDR_LSB];
        end else begin
          curTrim_q <= nvmRdData;
        end
      end else if (state_q == ST_IDLE && isWrite) begin
        // a whole byte per write transaction
        if (addrSysCfg) begin
          sysCfg_q <= cmdData; // override bit lands here, not yet adopted
        end else if (addrOwn) begin
          ownAddrReg_q <= cmdData[`BACR_OWN_ADDR_MSB:`BACR_OWN_ADDR_LSB];
        end else if (addrVid) begin
          vidAddrReg_q <= cmdData[`BACR_VID_ADDR_MSB:`BACR_VID_ADDR_LSB];
        end else if (addrTrim) begin
          curTrim_q <= cmdData;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // adopted addresses; the bus address changes only at a load after reset
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strapHeld_q <= 7'h00;
      ownAddress <= 7'h00;
      addressOverride <= 1'b0;
      vidAddress <= 4'h0;
      ready <= 1'b0;
      busy <= 1'b1;
    end else if (ce) begin
      busy <= (state_d != ST_IDLE);
      // strap caught by the clock after release, not by the reset itself
      if (state_q == ST_LOAD && slot_q == 2'h0) begin
        strapHeld_q <= strapAddr;
      end
      if (loadPend_q && loadSlot_q == `BACR_SLOT_LAST) begin
        ready <= 1'b1;
        // system config and own address already restored by now
        addressOverride <= sysCfg_q[`BACR_SYS_OVERRIDE_BIT];
        if (sysCfg_q[`BACR_SYS_OVERRIDE_BIT]) begin
          ownAddress <= ownAddrReg_q;
        end else begin
          ownAddress <= strapHeld_q;
        end
      end
      // reserved codes pass through unchanged; the host must not send them
      // vid address follows its register at once, codes map one to one
      vidAddress <= vidAddrReg_q;
    end
  end

  // ----------------------------------------------------------------------
  // transaction answer, one cycle after the request
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rspValid <= 1'b0;
      rspNack <= 1'b0;
      rspData <= 8'h00;
    end else if (ce) begin
      rspValid <= cmdValid;
      rspNack <= 1'b0;
      if (cmdValid) begin
        // busy sequencer or unknown offset refuses; reads then return zero;
        // the last restore edge is refused too: a write there would be lost
        // under the restore, and the own-address source is not adopted yet
        if (state_q != ST_IDLE || loadPend_q) begin
          rspNack <= 1'b1;
          rspData <= 8'h00;
        end else if (isRead) begin
          rspNack <= ~mapped;
          rspData <= readByte;
        end else begin
          rspNack <= ~(mapped | addrStore);
          rspData <= 8'h00;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // backup memory and current trim
  // ----------------------------------------------------------------------
  // one slot per cycle: the sequencer index doubles as the memory address
  bacr_nvm bacr_nvm_i (
    .clk(clk),
    .ce(ce),
    .wrEn(nvmWrEn),
    .addr(slot_q),
    .wrData(nvmWrData),
    .rdData(nvmRdData)
  );

  // trims are live: both codes are taken with each sample, so a write applies to samples taken after it
  bacr_trim bacr_trim_i (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .inValid(rawValid),
    .rawCur(rawCurrent),
    .gainCode(curTrim_q[`BACR_GAIN_MSB:`BACR_GAIN_LSB]),
    .ofsCode(curTrim_q[`BACR_OFS_MSB:`BACR_OFS_LSB]),
    .outValid(reportValid),
    .repCur(outputCurrentReport)
  );

endmodule

// ---- rtl/bacr_trim.v ----
// applies gain and offset trims to a raw output-current sample
// assumes raw samples in lsb of 0.25 A; two-cycle registered pipeline
`timescale 1ns/1ps
`include "bacr_regs.vh"

module bacr_trim (
  input wire clk,            // clock
  input wire reset_n,        // async reset, active low
  input wire ce,             // clock enable
  input wire inValid,        // raw sample strobe
  input wire [15:0] rawCur,  // raw converted current
  input wire [3:0] gainCode, // gain trim code
  input wire [3:0] ofsCode,  // offset trim code
  output reg outValid,       // report strobe
  output reg [15:0] repCur   // trimmed report
);

  reg stageValid_q;
  reg [15:0] scaled_q;
  reg [3:0] ofsHeld_q;
  wire [8:0] gainFactor;
  wire [31:0] product;
  wire [31:0] quotient;
  wire [15:0] ofsVal;

  // 0.5 % per code from -3.5 % at code 0
  assign gainFactor = `BACR_GAIN_BASE + {5'h00, gainCode};
  assign product = {16'h0000, rawCur} * {23'h000000, gainFactor};
  assign quotient = product / `BACR_GAIN_DIV;
  // codes from 1000b give +0.25 A upward, lower codes go negative
  assign ofsVal = ofsHeld_q[3] ?
    {11'h000, {1'b0, ofsHeld_q} - `BACR_OFS_POS_BIAS} :
    {{11{1'b1}}, {1'b0, ofsHeld_q} - `BACR_OFS_NEG_BIAS};

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stageValid_q <= 1'b0;
      scaled_q <= 16'h0000;
      ofsHeld_q <= 4'h0;
      outValid <= 1'b0;
      repCur <= 16'h0000;
    end else if (ce) begin
      stageValid_q <= inValid;
      if (inValid) begin
        scaled_q <= quotient[15:0];
        ofsHeld_q <= ofsCode;
      end
      outValid <= stageValid_q;
      if (stageValid_q) begin
        repCur <= scaled_q + ofsVal; // no clamp, a negative sum wraps
      end
    end
  end

endmodule

// ---- tb/bacr_host_model.sv ----
// management host stand-in issuing one-byte write and read transactions
// assumes the caller waits for ready before the first transaction
`timescale 1ns/1ps
module bacr_host_model (
  input logic clk, // clock
  output logic cmdValid, // request
  output logic cmdWrite, // write
  output logic [7:0] cmdAddr, // offset
  output logic [7:0] cmdData, // data
  input logic rspValid, // answer
  input logic rspNack, // refused
  input logic [7:0] rspData // read byte
);
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdAddr = 8'h00;
    cmdData = 8'h00;
  end

  // one byte per transaction; idle lines show the inverse so stale data
  // is never mistaken for a fresh request; reserved vid codes never sent
  task automatic xfer(input logic wr, input logic [7:0] adr, input logic [7:0] dat,
    output logic ok, output logic nack, output logic [7:0] q);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdAddr <= adr;
    cmdData <= dat;
    @(posedge clk);
    cmdValid <= 1'b0;
    cmdAddr <= ~adr;
    cmdData <= ~dat;
    #1;
    ok = rspValid;
    nack = rspNack;
    q = rspData;
  endtask
endmodule

// ---- tb/bacr_top_assertions.sv ----
// timing and field checks on the ports of the address and trim bank
// assumes one clock domain; bound to every instance of the top module
`timescale 1ns/1ps
`include "bacr_regs.vh"
module bacr_top_assertions (
  input logic clk, // clock
  input logic reset_n, // async reset
  input logic ce, // enable
  input logic [6:0] strapAddr, // strap
  input logic cmdValid, // request
  input logic cmdWrite, // write
  input logic [7:0] cmdAddr, // offset
  input logic [7:0] cmdData, // data
  input logic rawValid, // sample
  input logic [15:0] rawCurrent, // raw
  input logic rspValid, // answer
  input logic rspNack, // refused
  input logic [7:0] rspData, // read byte
  input logic ready, // loaded
  input logic busy, // busy
  input logic [6:0] ownAddress, // address
  input logic addressOverride, // override
  input logic [3:0] vidAddress, // vid
  input logic reportValid, // report
  input logic [15:0] outputCurrentReport // report
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  wire take = ce && cmdValid;
  wire idle = ready && !busy;
  wire mapped = cmdAddr == `BACR_OFS_SYS_CFG || cmdAddr == `BACR_OFS_OWN_ADDR ||
    cmdAddr == `BACR_OFS_VID_ADDR || cmdAddr == `BACR_OFS_CUR_TRIM ||
    (cmdWrite && cmdAddr == `BACR_OFS_STORE_ALL);

  a_answer_next: assert property (take |=> rspValid)
    else $error("request not answered next cycle");
  a_bad_offset: assert property (take && !mapped |=> rspValid && rspNack)
    else $error("unmapped offset accepted");
  a_served_ack: assert property (take && idle && mapped |=> !rspNack)
    else $error("mapped request refused while idle");
  a_busy_refuse: assert property (take && busy |=> rspNack)
    else $error("request accepted while busy");
  a_store_busy: assert property (take && idle && cmdWrite &&
    cmdAddr == `BACR_OFS_STORE_ALL |=> busy)
    else $error("store did not raise busy");
  a_own_bit7: assert property (take && !cmdWrite && cmdAddr == `BACR_OFS_OWN_ADDR
    |=> rspNack || !rspData[7])
    else $error("own address bit 7 read as one");
  a_vid_upper: assert property (take && !cmdWrite && cmdAddr == `BACR_OFS_VID_ADDR
    |=> rspNack || rspData[7:4] == 4'h0)
    else $error("vid upper bits not zero");
  a_vid_follows: assert property (take && idle && cmdWrite &&
    cmdAddr == `BACR_OFS_VID_ADDR |-> ##2 vidAddress == $past(cmdData[3:0], 2))
    else $error("vid address not adopted at once");
  // a low enable stretches the pipe, so latency counts enabled edges only
  a_report_lat: assert property (ce && rawValid ##1 ce |=> reportValid)
    else $error("report not two cycles after sample");
  a_report_cause: assert property (reportValid && $past(ce) && $past(ce, 2)
    |-> $past(rawValid, 2))
    else $error("report without sample");
  a_own_stable: assert property (ready && $past(ready) |-> $stable(ownAddress))
    else $error("own address changed without supply reset");
  a_own_strap: assert property ($rose(ready) && !addressOverride
    |-> ownAddress == strapAddr)
    else $error("strapped address not adopted");
endmodule

bind bacr_top bacr_top_assertions bacr_top_assertions_i (.clk(clk), .reset_n(reset_n),
  .ce(ce), .strapAddr(strapAddr), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
  .cmdAddr(cmdAddr), .cmdData(cmdData), .rawValid(rawValid), .rawCurrent(rawCurrent),
  .rspValid(rspValid), .rspNack(rspNack), .rspData(rspData), .ready(ready), .busy(busy),
  .ownAddress(ownAddress), .addressOverride(addressOverride), .vidAddress(vidAddress),
  .reportValid(reportValid), .outputCurrentReport(outputCurrentReport));

// ---- tb/test_bacr_top.sv ----
// self-checking bench of the address and current-trim register bank
// assumes factory memory contents from the shared header
`timescale 1ns/1ps
`include "bacr_regs.vh"
module test_bacr_top;
  logic clk, reset_n, ce, rawValid, cmdValid, cmdWrite, rspValid, rspNack;
  logic ready, busy, addressOverride, reportValid;
  logic [6:0] strapAddr, ownAddress;
  logic [7:0] cmdAddr, cmdData, rspData;
  logic [3:0] vidAddress;
  logic [15:0] rawCurrent, outputCurrentReport;
  integer bad_count = 0;
  integer checks = 0;

  bacr_top bacr_top_i (.clk(clk), .reset_n(reset_n), .ce(ce), .strapAddr(strapAddr),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .rawValid(rawValid), .rawCurrent(rawCurrent), .rspValid(rspValid),
    .rspNack(rspNack), .rspData(rspData), .ready(ready), .busy(busy),
    .ownAddress(ownAddress), .addressOverride(addressOverride),
    .vidAddress(vidAddress), .reportValid(reportValid),
    .outputCurrentReport(outputCurrentReport));
  bacr_host_model bacr_host_model_i (.clk(clk), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData), .rspValid(rspValid),
    .rspNack(rspNack), .rspData(rspData));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic en);
    logic ok, nk;
    logic [7:0] q;
    bacr_host_model_i.xfer(1'b1, a, d, ok, nk, q);
    chk("answer", 16'h1, ok);
    chk("refusal", en, nk);
  endtask

  task automatic rd(input logic [7:0] a, input logic en, input logic [7:0] e);
    logic ok, nk;
    logic [7:0] q;
    bacr_host_model_i.xfer(1'b0, a, 8'h00, ok, nk, q);
    chk("answer", 16'h1, ok);
    chk("refusal", en, nk);
    if (!en) chk("readData", e, q);
  endtask

  task automatic power_cycle(input logic [6:0] s);
    integer n;
    strapAddr <= s;
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("ready", 16'h1, ready);
  endtask

  // busy lasts four cycles after a store; a wait past 20 cycles counts as a hang
  task automatic wait_idle;
    integer n;
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("busy", 16'h0, busy);
  endtask

  task automatic t_defaults;
    chk("ownAddress", 16'h2A, ownAddress);
    chk("override", 16'h0, addressOverride);
    rd(`BACR_OFS_OWN_ADDR, 1'b0, 8'h2A);
    rd(`BACR_OFS_VID_ADDR, 1'b0, `BACR_DEF_VID_ADDR & 8'h0F);
    rd(`BACR_OFS_CUR_TRIM, 1'b0, `BACR_DEF_CUR_TRIM);
    rd(8'hA1, 1'b1, 8'h00);
    rd(`BACR_OFS_STORE_ALL, 1'b1, 8'h00);
    $display("defaults test done");
  endtask

  task automatic t_vid;
    for (int c = 0; c < 14; c++) begin
      wr(`BACR_OFS_VID_ADDR, {4'hF, c[3:0]}, 1'b0);
      @(posedge clk);
      #1;
      chk("vidAddress", c[3:0], vidAddress);
      rd(`BACR_OFS_VID_ADDR, 1'b0, {4'h0, c[3:0]});
    end
    $display("vid test done");
  endtask

  // gain in half-percent steps from -3.5 %, offset in 0.25 A steps, no clamp
  task automatic t_trim;
    logic [15:0] raw [4] = '{16'h0000, 16'h0190, 16'h0190, 16'h03E8};
    logic [7:0] code [4] = '{8'h00, 8'hFF, 8'h08, 8'h77};
    logic [15:0] want [4] = '{16'hFFF8, 16'h01A8, 16'h0183, 16'h03E7};
    for (int k = 0; k < 4; k++) begin
      wr(`BACR_OFS_CUR_TRIM, code[k], 1'b0);
      rd(`BACR_OFS_CUR_TRIM, 1'b0, code[k]);
      @(posedge clk);
      rawValid <= 1'b1;
      rawCurrent <= raw[k];
      @(posedge clk);
      rawValid <= 1'b0;
      rawCurrent <= ~raw[k];
      @(posedge clk);
      #1;
      chk("reportValid", 16'h1, reportValid);
      chk("report", want[k], outputCurrentReport);
    end
    $display("trim test done");
  endtask

  // a low enable holds the trim pipe; the report comes once it runs again
  task automatic t_freeze;
    @(posedge clk);
    rawValid <= 1'b1;
    rawCurrent <= 16'h0190;
    @(posedge clk);
    rawValid <= 1'b0;
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("frozenValid", 16'h0, reportValid);
    chk("frozenReport", 16'h03E7, outputCurrentReport);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    #1;
    chk("reportValid", 16'h1, reportValid);
    chk("report", 16'h018F, outputCurrentReport);
    $display("freeze test done");
  endtask

  task automatic t_address;
    wr(`BACR_OFS_OWN_ADDR, 8'hD5, 1'b0);
    rd(`BACR_OFS_OWN_ADDR, 1'b0, 8'h2A);
    wr(`BACR_OFS_SYS_CFG, 8'h01, 1'b0);
    rd(`BACR_OFS_SYS_CFG, 1'b0, 8'h01);
    wr(`BACR_OFS_STORE_ALL, 8'h00, 1'b0);
    chk("busy", 16'h1, busy);
    wr(`BACR_OFS_VID_ADDR, 8'h03, 1'b1);
    wait_idle;
    chk("ownAddress", 16'h2A, ownAddress);
    power_cycle(7'h2A);
    chk("ownAddress", 16'h55, ownAddress);
    chk("override", 16'h1, addressOverride);
    rd(`BACR_OFS_OWN_ADDR, 1'b0, 8'h55);
    wr(`BACR_OFS_SYS_CFG, 8'h00, 1'b0);
    wr(`BACR_OFS_STORE_ALL, 8'h00, 1'b0);
    wait_idle;
    power_cycle(7'h31);
    chk("ownAddress", 16'h31, ownAddress);
    $display("address test done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    strapAddr = 7'h00;
    rawValid = 1'b0;
    rawCurrent = 16'h0000;
    power_cycle(7'h2A);
    t_defaults;
    t_vid;
    t_trim;
    t_freeze;
    t_address;
    report_and_stop;
  end

  // the tests need well under ten thousand cycles
  initial begin
    #200000;
    bad_count++;
    report_and_stop;
  end
endmodule
